// >>> logic/dbf_pkg.sv
// Shared constants for the diagnostic ADC override and fault force block
package dbf_pkg;
  // Register port, result and channel geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int RES_W = 12;
  localparam int NUM_CH = 5;
  localparam int CH_W = 3;
  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [6:0] ADR_RAW_RESULT = 7'h2d;
  localparam logic [6:0] ADR_OVERRIDE_CTRL = 7'h2e;
  localparam logic [6:0] ADR_FAULT_INJ = 7'h2f;
  // Reset values
  localparam logic [15:0] RST_RAW_RESULT = 16'h0000;
  localparam logic [15:0] RST_OVERRIDE_CTRL = 16'h0000;
  localparam logic [15:0] RST_FAULT_INJ = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  // Override control fields
  localparam int BIT_RESULT_OVR_EN = 15;
  localparam int BIT_OFFSET_OVR_EN = 14;
  localparam int BIT_GND_SAMPLE_DIS = 13;
  localparam int OVR_DATA_LSB = 0;
  // Writable bits of the override control word (bit 12 reserved)
  localparam logic [15:0] OVR_WR_MASK = 16'hefff;
  // Fault injection fields
  localparam int BIT_CHECKSUM_FORCE = 15;
  localparam int BIT_REF_FORCE = 14;
  localparam int BIT_OT_ERR_FORCE = 13;
  localparam int BIT_OT_WARN_FORCE = 12;
  localparam int LIM_FORCE_LSB = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Monitored channel numbers; force bits sit at 2*ch (low), 2*ch+1 (high)
  localparam logic [2:0] CH_REFERENCE = 3'h0;
  localparam logic [2:0] CH_MAIN_SUPPLY = 3'h1;
  localparam logic [2:0] CH_CORE_SUPPLY = 3'h2;
  localparam logic [2:0] CH_ZERO_TEMPCO = 3'h3;
  localparam logic [2:0] CH_DAC_OUTPUT = 3'h4;
  ////////////////////////////////////////////////////////////////////////////
  // Ground sample phase before each conversion
  localparam int CLK_HZ = 25000000;
  localparam int GND_SAMPLE_NS = 400;
  localparam int GND_SAMPLE_CYC =
    ((GND_SAMPLE_NS * (CLK_HZ / 1000000)) + 999) / 1000;
  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_GND,
    SEQ_CONV
  } dbf_seq_e;
endpackage : dbf_pkg

// >>> logic/dbf_result_path.sv
// Selects the reported channel result and the offset applied to it
`timescale 1ns/1ps
module dbf_result_path
  import dbf_pkg::*;
#(
  parameter int RW = RES_W
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rstn, // Async reset, low
  input wire logic i_ce, // Clock enable
  input wire logic i_conv_valid, // Conversion done pulse
  input wire logic [CH_W-1:0] i_conv_chan, // Converted channel
  input wire logic [RW-1:0] i_conv_raw, // Uncorrected result
  input wire logic [RW-1:0] i_meas_offset, // Measured offset, signed
  input wire logic i_result_ovr_en, // Result override on
  input wire logic i_offset_ovr_en, // Offset override on
  input wire logic [RW-1:0] i_ovr_data, // Override field
  output logic o_valid, // Result pulse
  output logic [CH_W-1:0] o_chan, // Result channel
  output logic [RW-1:0] o_result, // Channel result
  output logic [RW-1:0] o_offset // Offset used
);
  initial begin
    if (RW < 2 || RW > 15) $error("dbf_result_path: bad RW");
  end
  // Data override outranks offset override
  wire offset_sel = i_offset_ovr_en && !i_result_ovr_en;
  wire [RW-1:0] offset_used = offset_sel ? i_ovr_data
                                         : i_meas_offset;
  // Signed correction with clamping to the converter range
  wire signed [RW+1:0] corr_full = $signed({2'b00, i_conv_raw})
    - $signed({{2{offset_used[RW-1]}}, offset_used});
  wire corr_neg = corr_full[RW+1];
  wire corr_ovf = !corr_full[RW+1] && corr_full[RW];
  wire [RW-1:0] corr_val = corr_neg ? '0
                         : corr_ovf ? '1 : corr_full[RW-1:0];
  // Override value replaces the whole result, offset disregarded
  wire [RW-1:0] result_sel = i_result_ovr_en ? i_ovr_data
                                             : corr_val;
  ////////////////////////////////////////////////////////////////////////////
  // Result registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_valid <= 1'b0;
      o_chan <= '0;
      o_result <= '0;
      o_offset <= '0;
    end else if (i_ce) begin
      o_valid <= i_conv_valid;
      if (i_conv_valid) begin
        o_chan <= i_conv_chan;
        o_result <= result_sel;
        o_offset <= i_result_ovr_en ? '0 : offset_used;
      end
    end
  end
endmodule : dbf_result_path

// >>> logic/dbf_limit_check.sv
// Per-channel high and low limit faults with software force
`timescale 1ns/1ps
module dbf_limit_check
  import dbf_pkg::*;
#(
  parameter int NCH = NUM_CH,
  parameter int RW = RES_W
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rstn, // Async reset, low
  input wire logic i_ce, // Clock enable
  input wire logic i_valid, // Result pulse
  input wire logic [CH_W-1:0] i_chan, // Result channel
  input wire logic [RW-1:0] i_result, // Channel result
  input wire logic [NCH*RW-1:0] i_lim_hi, // High limits
  input wire logic [NCH*RW-1:0] i_lim_lo, // Low limits
  input wire logic [NCH-1:0] i_force_hi, // High force bits
  input wire logic [NCH-1:0] i_force_lo, // Low force bits
  output logic [NCH-1:0] o_fault_hi, // High faults
  output logic [NCH-1:0] o_fault_lo // Low faults
);
  initial begin
    if (NCH < 1 || NCH > 8) $error("dbf_limit_check: bad NCH");
  end
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire hit = i_valid && (i_chan == CH_W'(g));
      wire [RW-1:0] hi_lim = i_lim_hi[g*RW +: RW];
      wire [RW-1:0] lo_lim = i_lim_lo[g*RW +: RW];
      // One flop pair per channel, so no vector has several writers
      logic hi_reg;
      logic lo_reg;
      // Judged on each conversion of this channel
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          hi_reg <= 1'b0;
          lo_reg <= 1'b0;
        end else if (i_ce && hit) begin
          hi_reg <= i_result > hi_lim;
          lo_reg <= i_result < lo_lim;
        end
      end
      // Force holds the fault as long as the bit stays set
      assign o_fault_hi[g] = hi_reg || i_force_hi[g];
      assign o_fault_lo[g] = lo_reg || i_force_lo[g];
    end
  endgenerate
endmodule : dbf_limit_check

// >>> logic/diag_adc_bypass_fault_inject.sv
// Diagnostic ADC override, raw result readback and fault force logic
//
// Contract
// - Raw result is 12 bits, top four zero
// - Raw result excludes the offset correction
// - Raw result ignores any override setting
// - Result override replaces result, ignores offset
// - Both overrides set: result override wins
// - Override lands in readback, drives limits
// - Offset override field read as signed
// - Ground sampling on unless disable bit set
// - Checksum force inverts sent CRC byte
// - Reference force reports reference failure
// - Overtemp error force reports high threshold
// - Overtemp warning force reports low threshold
// - Output monitor high/low forced independently
// - Zero-tempco monitor high/low forced independently
// - Core supply monitor high/low forced independently
// - Main supply monitor high/low forced independently
// - Reference monitor high/low forced independently
// - All force and override bits reset zero
// - Offset from measurement unless offset override
`timescale 1ns/1ps
module diag_adc_bypass_fault_inject
  import dbf_pkg::*;
#(
  parameter int GND_CYC = GND_SAMPLE_CYC
) (
  input wire logic i_clk, // Core clock, 25 MHz
  input wire logic i_rstn, // Async reset, low
  input wire logic i_ce, // Clock enable
  // Register port from the serial host interface
  input wire logic [ADDR_W-1:0] i_reg_addr, // Register address
  input wire logic i_reg_wr, // Write strobe
  input wire logic [DATA_W-1:0] i_reg_wdata, // Write data
  input wire logic i_reg_rd, // Read strobe
  output logic [DATA_W-1:0] o_reg_rdata, // Read data
  output logic o_reg_rvalid, // Read data valid
  output logic o_reg_hit, // Address owned here
  // Conversion engine
  input wire logic i_conv_req, // Conversion request
  input wire logic [CH_W-1:0] i_conv_req_chan, // Requested channel
  output logic o_conv_busy, // Sequencer busy
  output logic o_gnd_sample, // Ground sample phase
  output logic o_conv_start, // Start conversion
  output logic [CH_W-1:0] o_conv_chan, // Channel to convert
  input wire logic i_conv_valid, // Conversion done
  input wire logic [RES_W-1:0] i_conv_raw, // Raw result
  input wire logic [RES_W-1:0] i_meas_offset, // Measured offset
  // Channel readback and limits
  output logic o_rb_wr, // Readback write pulse
  output logic [CH_W-1:0] o_rb_chan, // Readback channel
  output logic [RES_W-1:0] o_rb_data, // Readback value
  output logic [RES_W-1:0] o_offset_used, // Offset applied
  input wire logic [NUM_CH*RES_W-1:0] i_lim_hi, // High limits
  input wire logic [NUM_CH*RES_W-1:0] i_lim_lo, // Low limits
  output logic [NUM_CH-1:0] o_limit_hi_fault, // High faults
  output logic [NUM_CH-1:0] o_limit_lo_fault, // Low faults
  // Analog monitors, asynchronous
  input wire logic i_ref_mon_trip, // Reference monitor
  input wire logic i_ot_err_mon, // Upper thermal comp
  input wire logic i_ot_warn_mon, // Lower thermal comp
  output logic o_ref_fault, // Reference failure
  output logic o_ot_error, // Overtemp error
  output logic o_ot_warning, // Overtemp warning
  // Serial output checksum
  input wire logic [7:0] i_crc_byte, // Computed CRC byte
  output logic [7:0] o_crc_byte // CRC byte to send
);
  initial begin
    if (GND_CYC < 1 || GND_CYC > 255) $error("dbf: bad GND_CYC");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [DATA_W-1:0] raw_result_reg;
  logic [DATA_W-1:0] override_ctrl_reg;
  logic [DATA_W-1:0] fault_inj_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic rvalid_reg;
  // Address decode
  wire sel_raw = i_reg_addr == ADR_RAW_RESULT;
  wire sel_ovr = i_reg_addr == ADR_OVERRIDE_CTRL;
  wire sel_inj = i_reg_addr == ADR_FAULT_INJ;
  wire wr_ovr = i_reg_wr && sel_ovr;
  wire wr_inj = i_reg_wr && sel_inj;
  // Field views of the control words
  wire result_ovr_en = override_ctrl_reg[BIT_RESULT_OVR_EN];
  wire offset_ovr_en = override_ctrl_reg[BIT_OFFSET_OVR_EN];
  wire gnd_sample_dis = override_ctrl_reg[BIT_GND_SAMPLE_DIS];
  wire [RES_W-1:0] ovr_data = override_ctrl_reg[OVR_DATA_LSB +: RES_W];
  wire checksum_force = fault_inj_reg[BIT_CHECKSUM_FORCE];
  wire ref_force = fault_inj_reg[BIT_REF_FORCE];
  wire ot_err_force = fault_inj_reg[BIT_OT_ERR_FORCE];
  wire ot_warn_force = fault_inj_reg[BIT_OT_WARN_FORCE];
  wire [2*NUM_CH-1:0] lim_force =
    fault_inj_reg[LIM_FORCE_LSB +: 2*NUM_CH];
  ////////////////////////////////////////////////////////////////////////////
  // Write side; read-only raw result ignores writes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      override_ctrl_reg <= RST_OVERRIDE_CTRL;
      fault_inj_reg <= RST_FAULT_INJ;
    end else if (i_ce) begin
      if (wr_ovr) begin
        override_ctrl_reg <= i_reg_wdata & OVR_WR_MASK;
      end
      if (wr_inj) begin
        fault_inj_reg <= i_reg_wdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Raw result capture straight from the converter, before any
  // correction or override, so software can always see real data
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      raw_result_reg <= RST_RAW_RESULT;
    end else if (i_ce && i_conv_valid) begin
      raw_result_reg <= {4'h0, i_conv_raw};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read mux, registered so read data comes from flip-flops
  wire [DATA_W-1:0] rd_mux = sel_raw ? raw_result_reg
                           : sel_ovr ? override_ctrl_reg
                           : sel_inj ? fault_inj_reg : 16'h0000;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else if (i_ce) begin
      rvalid_reg <= i_reg_rd;
      if (i_reg_rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end
  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;
  assign o_reg_hit = sel_raw || sel_ovr || sel_inj;
  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer: optional ground sample phase to drain the
  // sampling capacitor, then one start pulse. Trades a few cycles of
  // latency per conversion for less crosstalk between channels.
  dbf_seq_e seq_reg;
  dbf_seq_e seq_next;
  logic [7:0] gnd_cnt_reg;
  logic [CH_W-1:0] chan_reg;
  logic start_reg;
  wire gnd_done = gnd_cnt_reg == 8'(GND_CYC - 1);
  // Next state
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      SEQ_IDLE: begin
        if (i_conv_req) begin
          seq_next = gnd_sample_dis ? SEQ_CONV : SEQ_GND;
        end
      end
      SEQ_GND: begin
        if (gnd_done) begin
          seq_next = SEQ_CONV;
        end
      end
      SEQ_CONV: begin
        if (i_conv_valid) begin
          seq_next = SEQ_IDLE;
        end
      end
      default: begin
        seq_next = SEQ_IDLE;
      end
    endcase
  end
  // State, counter and channel latch
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seq_reg <= SEQ_IDLE;
      gnd_cnt_reg <= 8'h00;
      chan_reg <= '0;
    end else if (i_ce) begin
      seq_reg <= seq_next;
      gnd_cnt_reg <= (seq_reg == SEQ_GND) ? gnd_cnt_reg + 8'h01 : 8'h00;
      if (seq_reg == SEQ_IDLE && i_conv_req) begin
        chan_reg <= i_conv_req_chan;
      end
    end
  end
  // One start pulse on entry to the conversion state
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      start_reg <= 1'b0;
    end else if (i_ce) begin
      start_reg <= (seq_next == SEQ_CONV) && (seq_reg != SEQ_CONV);
    end
  end
  assign o_conv_busy = seq_reg != SEQ_IDLE;
  assign o_gnd_sample = seq_reg == SEQ_GND;
  assign o_conv_start = start_reg;
  assign o_conv_chan = chan_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Result selection; override priority lives in the result path
  logic res_valid;
  logic [CH_W-1:0] res_chan;
  logic [RES_W-1:0] res_value;
  dbf_result_path #(
    .RW(RES_W)
  ) u_result (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_conv_valid(i_conv_valid),
    .i_conv_chan(chan_reg),
    .i_conv_raw(i_conv_raw),
    .i_meas_offset(i_meas_offset),
    .i_result_ovr_en(result_ovr_en),
    .i_offset_ovr_en(offset_ovr_en),
    .i_ovr_data(ovr_data),
    .o_valid(res_valid),
    .o_chan(res_chan),
    .o_result(res_value),
    .o_offset(o_offset_used)
  );
  // Readback write for the converted channel
  assign o_rb_wr = res_valid;
  assign o_rb_chan = res_chan;
  assign o_rb_data = res_value;
  ////////////////////////////////////////////////////////////////////////////
  // Limit faults: force bits sit low/high in pairs per channel
  logic [NUM_CH-1:0] force_hi;
  logic [NUM_CH-1:0] force_lo;
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_force
      assign force_lo[c] = lim_force[2*c];
      assign force_hi[c] = lim_force[2*c+1];
    end
  endgenerate
  dbf_limit_check #(
    .NCH(NUM_CH),
    .RW(RES_W)
  ) u_limits (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_valid(res_valid),
    .i_chan(res_chan),
    .i_result(res_value),
    .i_lim_hi(i_lim_hi),
    .i_lim_lo(i_lim_lo),
    .i_force_hi(force_hi),
    .i_force_lo(force_lo),
    .o_fault_hi(o_limit_hi_fault),
    .o_fault_lo(o_limit_lo_fault)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Analog monitor synchronisers; first stage feeds only the second
  logic [2:0] mon_s1_reg;
  logic [2:0] mon_s2_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mon_s1_reg <= 3'h0;
      mon_s2_reg <= 3'h0;
    end else if (i_ce) begin
      mon_s1_reg <= {i_ot_warn_mon, i_ot_err_mon, i_ref_mon_trip};
      mon_s2_reg <= mon_s1_reg;
    end
  end
  // Forced faults merge with the real trips onto the same flags
  logic ref_fault_reg;
  logic ot_error_reg;
  logic ot_warning_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_fault_reg <= 1'b0;
      ot_error_reg <= 1'b0;
      ot_warning_reg <= 1'b0;
    end else if (i_ce) begin
      ref_fault_reg <= mon_s2_reg[0] || ref_force;
      ot_error_reg <= mon_s2_reg[1] || ot_err_force;
      ot_warning_reg <= mon_s2_reg[2] || ot_warn_force;
    end
  end
  assign o_ref_fault = ref_fault_reg;
  assign o_ot_error = ot_error_reg;
  assign o_ot_warning = ot_warning_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Checksum corruption; combinational so the byte stays in step with
  // the serializer that supplies it
  assign o_crc_byte = checksum_force ? ~i_crc_byte : i_crc_byte;
endmodule : diag_adc_bypass_fault_inject

// >>> verif/dbf_chk_assertions.sv
// Port-level checker for the override and fault force block
`timescale 1ns/1ps
module dbf_chk
  import dbf_pkg::*;
#(
  parameter int GND_CYC = 10
) (
  input wire logic i_clk, // Clock
  input wire logic i_rstn, // Reset, low
  input wire logic i_ce, // Enable
  input wire logic [ADDR_W-1:0] i_reg_addr, // Address
  input wire logic i_reg_wr, // Write
  input wire logic [DATA_W-1:0] i_reg_wdata, // Wdata
  input wire logic i_reg_rd, // Read
  input wire logic [DATA_W-1:0] o_reg_rdata, // Rdata
  input wire logic o_reg_rvalid, // Rvalid
  input wire logic i_conv_req, // Conv request
  input wire logic o_conv_busy, // Busy
  input wire logic o_gnd_sample, // Ground phase
  input wire logic o_conv_start, // Start
  input wire logic i_conv_valid, // Conv done
  input wire logic [RES_W-1:0] i_meas_offset, // Offset in
  input wire logic o_rb_wr, // Readback pulse
  input wire logic [RES_W-1:0] o_rb_data, // Readback
  input wire logic [RES_W-1:0] o_offset_used, // Offset out
  input wire logic [NUM_CH-1:0] o_limit_hi_fault, // High faults
  input wire logic [NUM_CH-1:0] o_limit_lo_fault, // Low faults
  input wire logic o_ref_fault, // Ref fault
  input wire logic o_ot_error, // Overtemp error
  input wire logic o_ot_warning, // Overtemp warning
  input wire logic [7:0] i_crc_byte, // CRC in
  input wire logic [7:0] o_crc_byte // CRC out
);
  logic [15:0] ov_reg;
  logic [15:0] fi_reg;
  // Shadow control words; the design's copies are not visible at the ports
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ov_reg <= '0;
      fi_reg <= '0;
    end else if (i_ce && i_reg_wr) begin
      if (i_reg_addr == ADR_OVERRIDE_CTRL) ov_reg <= i_reg_wdata;
      if (i_reg_addr == ADR_FAULT_INJ) fi_reg <= i_reg_wdata;
    end
  end
  // Force bits split per channel: high at odd, low at even positions
  wire logic [4:0] f_hi =
    {fi_reg[9], fi_reg[7], fi_reg[5], fi_reg[3], fi_reg[1]};
  wire logic [4:0] f_lo =
    {fi_reg[8], fi_reg[6], fi_reg[4], fi_reg[2], fi_reg[0]};
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_take;
    i_ce && i_conv_req && !o_conv_busy;
  endsequence
  sequence s_done;
    i_ce && i_conv_valid && o_conv_busy;
  endsequence
  // Forced flags pass only the output register, so allow one cycle
  property p_force(logic f, logic o);
    f ##1 f |-> o;
  endproperty
  AST_RAW_TOP: assert property (
    i_ce && i_reg_rd && i_reg_addr == ADR_RAW_RESULT |=>
      o_reg_rvalid && o_reg_rdata[15:12] == 4'h0)
    else $error("raw result upper bits not zero");
  AST_GND_ON: assert property (
    s_take ##0 !ov_reg[13] |=> o_gnd_sample && !o_conv_start)
    else $error("ground phase missing");
  AST_GND_OFF: assert property (
    s_take ##0 ov_reg[13] |=> !o_gnd_sample && o_conv_start)
    else $error("ground phase not skipped");
  AST_RES_OVR: assert property (
    s_done ##0 ov_reg[15] |=> o_rb_wr && o_offset_used == 12'h000 &&
      o_rb_data == $past(ov_reg[11:0]))
    else $error("result override not applied");
  AST_OFS_SRC: assert property (
    s_done ##0 !ov_reg[15] |=> o_offset_used == ($past(ov_reg[14]) ?
      $past(ov_reg[11:0]) : $past(i_meas_offset)))
    else $error("wrong offset source");
  AST_CRC: assert property (
    o_crc_byte == (fi_reg[15] ? ~i_crc_byte : i_crc_byte))
    else $error("checksum byte wrong");
  AST_LIM_HI: assert property (
    (f_hi & ~o_limit_hi_fault) == 5'h00)
    else $error("forced high fault missing");
  AST_LIM_LO: assert property (
    (f_lo & ~o_limit_lo_fault) == 5'h00)
    else $error("forced low fault missing");
  AST_REF: assert property (p_force(fi_reg[14], o_ref_fault))
    else $error("forced reference fault missing");
  AST_OTE: assert property (p_force(fi_reg[13], o_ot_error))
    else $error("forced overtemp error missing");
  AST_OTW: assert property (p_force(fi_reg[12], o_ot_warning))
    else $error("forced overtemp warning missing");
endmodule : dbf_chk

bind diag_adc_bypass_fault_inject dbf_chk #(.GND_CYC(GND_CYC)) u_chk (
  .i_clk, .i_rstn, .i_ce, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd,
  .o_reg_rdata, .o_reg_rvalid, .i_conv_req, .o_conv_busy, .o_gnd_sample,
  .o_conv_start, .i_conv_valid, .i_meas_offset, .o_rb_wr, .o_rb_data,
  .o_offset_used, .o_limit_hi_fault, .o_limit_lo_fault, .o_ref_fault,
  .o_ot_error, .o_ot_warning, .i_crc_byte, .o_crc_byte
);

// >>> verif/dbf_host_model.sv
// Host-side register driver for the override and fault force block
`timescale 1ns/1ps
module dbf_host_model
  import dbf_pkg::*;
(
  input wire logic i_clk, // Core clock
  output logic [ADDR_W-1:0] o_addr, // Register address
  output logic o_wr, // Write strobe
  output logic [DATA_W-1:0] o_wdata, // Write data
  output logic o_rd // Read strobe
);
  // Bus idle at time zero
  initial begin
    o_wr = 0;
    o_rd = 0;
    o_addr = '0;
    o_wdata = '0;
  end
  // One strobe cycle per word; released lines show the inverse value
  task automatic wr(logic [6:0] a, logic [15:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1;
    @(negedge i_clk);
    o_wr = 0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr
  task automatic rd(logic [6:0] a);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1;
    @(negedge i_clk);
    o_rd = 0;
    o_addr = ~a;
  endtask : rd
endmodule : dbf_host_model

// >>> verif/tb.sv
// Self-checking bench for the override and fault force block
`timescale 1ns/1ps
module tb;
  import dbf_pkg::*;
  localparam int GC = 2;
  logic i_clk = 0, i_rstn = 0, i_ce = 1;
  logic [ADDR_W-1:0] i_reg_addr;
  logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_reg_hit;
  logic [DATA_W-1:0] i_reg_wdata, o_reg_rdata;
  logic i_conv_req = 0, i_conv_valid = 0, o_conv_busy, o_gnd_sample;
  logic o_conv_start, o_rb_wr, o_ref_fault, o_ot_error, o_ot_warning;
  logic [CH_W-1:0] i_conv_req_chan = 0, o_conv_chan, o_rb_chan;
  logic [RES_W-1:0] i_conv_raw = 0, i_meas_offset = 0;
  logic [RES_W-1:0] o_rb_data, o_offset_used, last_r;
  logic [NUM_CH*RES_W-1:0] i_lim_hi = '1, i_lim_lo = '0;
  logic [NUM_CH-1:0] o_limit_hi_fault, o_limit_lo_fault;
  logic i_ref_mon_trip = 0, i_ot_err_mon = 0, i_ot_warn_mon = 0;
  logic [7:0] i_crc_byte = 0, o_crc_byte;
  int num_errors = 0, checked = 0;
  logic [31:0] qr[$], qb[$];
  always #20 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////
  diag_adc_bypass_fault_inject #(.GND_CYC(GC)) u_dut (
    .i_clk, .i_rstn, .i_ce, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd,
    .o_reg_rdata, .o_reg_rvalid, .o_reg_hit, .i_conv_req, .i_conv_req_chan,
    .o_conv_busy, .o_gnd_sample, .o_conv_start, .o_conv_chan, .i_conv_valid,
    .i_conv_raw, .i_meas_offset, .o_rb_wr, .o_rb_chan, .o_rb_data,
    .o_offset_used, .i_lim_hi, .i_lim_lo, .o_limit_hi_fault,
    .o_limit_lo_fault, .i_ref_mon_trip, .i_ot_err_mon, .i_ot_warn_mon,
    .o_ref_fault, .o_ot_error, .o_ot_warning, .i_crc_byte, .o_crc_byte
  );
  dbf_host_model u_host (
    .i_clk, .o_addr(i_reg_addr), .o_wr(i_reg_wr), .o_wdata(i_reg_wdata),
    .o_rd(i_reg_rd)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // Raw minus signed offset, clamped to the result range
  function automatic logic [11:0] corr(logic [11:0] r, logic [11:0] o);
    int v;
    v = int'(r) - int'($signed(o));
    return (v < 0) ? 12'h000 : ((v > 4095) ? 12'hfff : v[11:0]);
  endfunction : corr
  task automatic rd(logic [6:0] a, logic [15:0] e);
    qr.push_back(32'(e));
    u_host.rd(a);
  endtask : rd
  // One conversion with random raw data and measured offset
  task automatic conv(logic [15:0] c, logic [2:0] ch);
    logic [11:0] o;
    int k;
    last_r = 12'($urandom);
    o = 12'($urandom);
    @(negedge i_clk);
    i_conv_req = 1;
    i_conv_req_chan = ch;
    @(negedge i_clk);
    i_conv_req = 0;
    i_conv_req_chan = ~ch;
    for (k = 0; k < 40 && o_conv_start !== 1'b1; k++) @(negedge i_clk);
    if (k == 40) chk(0, 1);
    chk(o_conv_chan, ch);
    @(negedge i_clk);
    i_conv_valid = 1;
    i_conv_raw = last_r;
    i_meas_offset = o;
    qb.push_back({ch, (c[15] ? c[11:0] :
      corr(last_r, c[14] ? c[11:0] : o))});
    @(negedge i_clk);
    i_conv_valid = 0;
    i_conv_raw = ~last_r;
    i_meas_offset = ~o;
    rd(ADR_RAW_RESULT, {4'h0, last_r});
  endtask : conv
  // Result watcher: oldest note against each answer
  always @(posedge i_clk) begin
    if (o_reg_rvalid === 1'b1) chk(32'(o_reg_rdata), qr.pop_front());
    if (i_reg_rd === 1'b1) chk(o_reg_hit, i_reg_addr inside
      {ADR_RAW_RESULT, ADR_OVERRIDE_CTRL, ADR_FAULT_INJ});
    if (o_rb_wr === 1'b1) chk({o_rb_chan, o_rb_data}, qb.pop_front());
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] ctl, v;
    void'($urandom(87659));
    i_crc_byte = 8'($urandom);
    repeat (8) @(negedge i_clk);
    i_rstn = 1;
    rd(ADR_RAW_RESULT, 16'h0000);
    rd(ADR_OVERRIDE_CTRL, 16'h0000);
    rd(ADR_FAULT_INJ, 16'h0000);
    // Modes: none, offset, data, then both at once for the priority case
    for (int m = 0; m < 4; m++) begin
      ctl = {m[1], m[0], m[0], 1'b1, 12'($urandom)};
      u_host.wr(ADR_OVERRIDE_CTRL, ctl);
      rd(ADR_OVERRIDE_CTRL, ctl & 16'hefff);
      conv(ctl, 3'(m));
    end
    // Overridden value is what the limits judge
    i_lim_hi = '0;
    u_host.wr(ADR_OVERRIDE_CTRL, 16'h8800);
    conv(16'h8800, 3'd4);
    chk(o_limit_hi_fault, 5'h10);
    i_lim_hi = '1;
    conv(16'h8800, 3'd4);
    chk(o_limit_hi_fault, 5'h00);
    // Read-only and unmapped places
    u_host.wr(ADR_RAW_RESULT, 16'hffff);
    rd(ADR_RAW_RESULT, {4'h0, last_r});
    rd(7'h30, 16'h0000);
    // Each force bit alone, held and seen on its own output
    for (int b = 0; b < 16; b++) begin
      v = 16'h1 << b;
      u_host.wr(ADR_FAULT_INJ, v);
      rd(ADR_FAULT_INJ, v);
      repeat (2) @(negedge i_clk);
      chk({o_crc_byte, o_ref_fault, o_ot_error, o_ot_warning,
        o_limit_hi_fault, o_limit_lo_fault},
        {(b == 15 ? ~i_crc_byte : i_crc_byte), b == 14, b == 13, b == 12,
        v[9], v[7], v[5], v[3], v[1], v[8], v[6], v[4], v[2], v[0]});
    end
    // Second reset clears the forced state
    i_rstn = 0;
    @(negedge i_clk);
    i_rstn = 1;
    rd(ADR_FAULT_INJ, 16'h0000);
    // Genuine monitor trips take the same outputs
    {i_ref_mon_trip, i_ot_err_mon, i_ot_warn_mon} = 3'b111;
    repeat (6) @(negedge i_clk);
    chk({o_ref_fault, o_ot_error, o_ot_warning}, 3'b111);
    {i_ref_mon_trip, i_ot_err_mon, i_ot_warn_mon} = 3'b000;
    repeat (6) @(negedge i_clk);
    chk({o_ref_fault, o_ot_error, o_ot_warning, o_crc_byte},
      {3'b000, i_crc_byte});
    chk(qr.size() + qb.size(), 0);
    results();
  end
endmodule : tb
